// ---- ppfm_regs.svh ----
// Register offsets, field positions and reset values of the port block
`ifndef PPFM_REGS_SVH
`define PPFM_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PPFM_OFS_P0_OUT    12'h000
`define PPFM_OFS_P0_DIR    12'h004
`define PPFM_OFS_P0_PU     12'h008
`define PPFM_OFS_P0_IN     12'h00C
`define PPFM_OFS_P2_OUT    12'h010
`define PPFM_OFS_P2_DIR    12'h014
`define PPFM_OFS_P2_CTL    12'h018
`define PPFM_OFS_P2_IN     12'h01C
`define PPFM_OFS_P4_OUT    12'h020
`define PPFM_OFS_P4_DIR    12'h024
`define PPFM_OFS_P4_PU     12'h028
`define PPFM_OFS_P4_IN     12'h02C
`define PPFM_OFS_EDGE      12'h030
`define PPFM_OFS_SER_CFG   12'h034
`define PPFM_OFS_IRQ_STAT  12'h038
`define PPFM_OFS_IRQ_MASK  12'h03C

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define PPFM_P2_BIT_CLK    0
`define PPFM_P2_BIT_SO     1
`define PPFM_P2_BIT_SI     2
`define PPFM_P2_BIT_TMR    3
`define PPFM_P2_BIT_CPT    4
`define PPFM_SER_ASYNC     0
`define PPFM_SER_CLK_OUT   1
`define PPFM_IRQ_A         0
`define PPFM_IRQ_B         1
`define PPFM_IRQ_KEY       2
`define PPFM_RST_BYTE      8'h00
`define PPFM_RST_DIR       8'hFF
`define PPFM_RST_EDGE      4'h0

`endif

// ---- ppfm_pkg.sv ----
// Types shared by the port block
package ppfm_pkg;
  // Valid edge of one external interrupt input
  typedef enum logic [1:0] {
    PPFM_EDGE_RISE = 2'h0,
    PPFM_EDGE_FALL = 2'h1,
    PPFM_EDGE_BOTH = 2'h2,
    PPFM_EDGE_OFF = 2'h3
  } ppfm_edge_e;
  typedef logic [7:0] ppfm_byte_t;
endpackage : ppfm_pkg

// ---- ppfm_edge_det.sv ----
// Edge detector of one external interrupt input with selectable edge
`timescale 1ns/100ps
module ppfm_edge_det (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Level and edge choice
  input wire logic level_in,
  input wire logic [1:0] edge_sel,
  // Detection pulse
  output logic hit
);
  logic prev_reg;
  logic prev_next;
  logic armed_reg;
  logic armed_next;
  logic hit_next;
  logic rise;
  logic fall;

  // Compare with last sample; encoding 3 disables the input
  always_comb begin
    prev_next = level_in;
    armed_next = 1'b1;
    rise = level_in & ~prev_reg;
    fall = ~level_in & prev_reg;
    unique case (ppfm_pkg::ppfm_edge_e'(edge_sel))
      ppfm_pkg::PPFM_EDGE_RISE: hit_next = rise;
      ppfm_pkg::PPFM_EDGE_FALL: hit_next = fall;
      ppfm_pkg::PPFM_EDGE_BOTH: hit_next = rise | fall;
      ppfm_pkg::PPFM_EDGE_OFF: hit_next = 1'b0;
    endcase
    // First sample only primes, so a pin high at reset gives no false rise
    if (!armed_reg) begin
      hit_next = 1'b0;
    end
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
      armed_reg <= 1'b0;
      hit <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      armed_reg <= armed_next;
      hit <= hit_next;
    end
  end

  AST_EDGE_RISE: assert property (@(posedge pclk)
    disable iff (!presetn)
    (armed_reg && edge_sel == 2'h0 && level_in && !$past(level_in)) |=> hit)
    else $error("rising edge missed");
endmodule : ppfm_edge_det

// ---- ppfm_apb_slave.sv ----
// APB slave register file of the port block
`timescale 1ns/100ps
`include "ppfm_regs.svh"
module ppfm_apb_slave (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Register contents
  output logic [7:0] p0_out_reg,
  output logic [7:0] p0_dir_reg,
  output logic [7:0] p0_pu_reg,
  output logic [7:0] p2_out_reg,
  output logic [7:0] p2_dir_reg,
  output logic [7:0] p2_ctl_reg,
  output logic [7:0] p4_out_reg,
  output logic [7:0] p4_dir_reg,
  output logic [7:0] p4_pu_reg,
  output logic [3:0] edge_reg,
  output logic [1:0] ser_reg,
  output logic [2:0] mask_reg,
  output logic [2:0] stat_reg,
  // Pin states and events
  input wire logic [7:0] p0_in,
  input wire logic [7:0] p2_in,
  input wire logic [7:0] p4_in,
  input wire logic [2:0] events
);
  logic wr;
  logic [2:0] stat_next;
  logic [31:0] rd_next;
  logic err_next;

  // Single wait-free access phase; write at pready edge
  assign wr = psel & penable & pwrite;

  // Sticky status: set wins over write-one clear
  always_comb begin
    stat_next = stat_reg;
    if (wr && paddr == `PPFM_OFS_IRQ_STAT) begin
      stat_next = stat_reg & ~pwdata[2:0];
    end
    stat_next = stat_next | events;
  end

  // Read mux, unmapped addresses answer with an error
  always_comb begin
    rd_next = 32'h0000_0000;
    err_next = 1'b0;
    unique case (paddr)
      `PPFM_OFS_P0_OUT: rd_next[7:0] = p0_out_reg;
      `PPFM_OFS_P0_DIR: rd_next[7:0] = p0_dir_reg;
      `PPFM_OFS_P0_PU: rd_next[7:0] = p0_pu_reg;
      `PPFM_OFS_P0_IN: rd_next[7:0] = p0_in;
      `PPFM_OFS_P2_OUT: rd_next[7:0] = p2_out_reg;
      `PPFM_OFS_P2_DIR: rd_next[7:0] = p2_dir_reg;
      `PPFM_OFS_P2_CTL: rd_next[7:0] = p2_ctl_reg;
      `PPFM_OFS_P2_IN: rd_next[7:0] = p2_in;
      `PPFM_OFS_P4_OUT: rd_next[7:0] = p4_out_reg;
      `PPFM_OFS_P4_DIR: rd_next[7:0] = p4_dir_reg;
      `PPFM_OFS_P4_PU: rd_next[7:0] = p4_pu_reg;
      `PPFM_OFS_P4_IN: rd_next[7:0] = p4_in;
      `PPFM_OFS_EDGE: rd_next[3:0] = edge_reg;
      `PPFM_OFS_SER_CFG: rd_next[1:0] = ser_reg;
      `PPFM_OFS_IRQ_STAT: rd_next[2:0] = stat_reg;
      `PPFM_OFS_IRQ_MASK: rd_next[2:0] = mask_reg;
      default: err_next = 1'b1;
    endcase
  end

  // Registers; direction resets to all inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p0_out_reg <= `PPFM_RST_BYTE;
      p0_dir_reg <= `PPFM_RST_DIR;
      p0_pu_reg <= `PPFM_RST_BYTE;
      p2_out_reg <= `PPFM_RST_BYTE;
      p2_dir_reg <= `PPFM_RST_DIR;
      p2_ctl_reg <= `PPFM_RST_BYTE;
      p4_out_reg <= `PPFM_RST_BYTE;
      p4_dir_reg <= `PPFM_RST_DIR;
      p4_pu_reg <= `PPFM_RST_BYTE;
      edge_reg <= `PPFM_RST_EDGE;
      ser_reg <= 2'h0;
      mask_reg <= 3'h0;
      stat_reg <= 3'h0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & err_next;
      prdata <= (psel & ~penable & ~pwrite) ? rd_next : 32'h0000_0000;
      if (wr) begin
        unique case (paddr)
          `PPFM_OFS_P0_OUT: p0_out_reg <= pwdata[7:0];
          `PPFM_OFS_P0_DIR: p0_dir_reg <= pwdata[7:0];
          `PPFM_OFS_P0_PU: p0_pu_reg <= pwdata[7:0];
          `PPFM_OFS_P2_OUT: p2_out_reg <= pwdata[7:0];
          `PPFM_OFS_P2_DIR: p2_dir_reg <= pwdata[7:0];
          `PPFM_OFS_P2_CTL: p2_ctl_reg <= pwdata[7:0];
          `PPFM_OFS_P4_OUT: p4_out_reg <= pwdata[7:0];
          `PPFM_OFS_P4_DIR: p4_dir_reg <= pwdata[7:0];
          `PPFM_OFS_P4_PU: p4_pu_reg <= pwdata[7:0];
          `PPFM_OFS_EDGE: edge_reg <= pwdata[3:0];
          `PPFM_OFS_SER_CFG: ser_reg <= pwdata[1:0];
          `PPFM_OFS_IRQ_MASK: mask_reg <= pwdata[2:0];
          default: ;
        endcase
      end
    end
  end

  AST_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    events[0] |=> stat_reg[0])
    else $error("event lost from status");
endmodule : ppfm_apb_slave

// ---- ppfm_port_top.sv ----
// Three-port pin block with direction, pull-up and alternate functions
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "ppfm_regs.svh"
// Operation
// - Plain port direction per pin
// - Plain port pull-up only on inputs
// - All pins inputs after reset
// - Shared port direction per pin
// - Shared port per-bit control operation select
// - Bits 0-2 carry serial clock/data
// - Bit 3 timer out, bit 4 capture
// - Key port direction and pull-ups
// - Key port feeds key return, IRQs
// - IRQ edge rising, falling or both
module ppfm_port_top #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Plain port pins
  input wire logic [WIDTH-1:0] plain_port_pins_i,
  output logic [WIDTH-1:0] plain_port_pins_o,
  output logic [WIDTH-1:0] plain_port_pins_oe,
  output logic [WIDTH-1:0] plain_port_pullup,
  // Shared serial/timer port pins
  input wire logic [WIDTH-1:0] shared_port_i,
  output logic [WIDTH-1:0] shared_port_o,
  output logic [WIDTH-1:0] shared_port_oe,
  // Key/interrupt port pins
  input wire logic [WIDTH-1:0] key_port_i,
  output logic [WIDTH-1:0] key_port_o,
  output logic [WIDTH-1:0] key_port_oe,
  output logic [WIDTH-1:0] key_port_pullup,
  // Serial interface side
  input wire logic sync_serial_clock_out,
  input wire logic sync_serial_data_out,
  input wire logic async_transmit_data,
  output logic sync_serial_clock_in,
  output logic async_serial_clock_in,
  output logic sync_serial_data_in,
  output logic async_receive_data,
  // Timer side
  input wire logic timer_b_output,
  output logic capture_edge_in,
  // Key return and interrupts
  output logic [WIDTH-1:0] key_return_inputs,
  output logic ext_irq_a,
  output logic ext_irq_b,
  output logic irq
);
  // --------------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------------
  if (WIDTH != 8) begin : g_bad_width
    $error("port block supports eight pins only");
  end

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic [7:0] p0_out_reg;
  logic [7:0] p0_dir_reg;
  logic [7:0] p0_pu_reg;
  logic [7:0] p2_out_reg;
  logic [7:0] p2_dir_reg;
  logic [7:0] p2_ctl_reg;
  logic [7:0] p4_out_reg;
  logic [7:0] p4_dir_reg;
  logic [7:0] p4_pu_reg;
  logic [3:0] edge_reg;
  logic [1:0] ser_reg;
  logic [2:0] mask_reg;
  logic [2:0] stat_reg;
  logic [2:0] events;
  logic hit_a;
  logic hit_b;
  logic key_hit;
  logic [7:0] key_prev_reg;

  ppfm_apb_slave u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .p0_out_reg(p0_out_reg),
    .p0_dir_reg(p0_dir_reg),
    .p0_pu_reg(p0_pu_reg),
    .p2_out_reg(p2_out_reg),
    .p2_dir_reg(p2_dir_reg),
    .p2_ctl_reg(p2_ctl_reg),
    .p4_out_reg(p4_out_reg),
    .p4_dir_reg(p4_dir_reg),
    .p4_pu_reg(p4_pu_reg),
    .edge_reg(edge_reg),
    .ser_reg(ser_reg),
    .mask_reg(mask_reg),
    .stat_reg(stat_reg),
    .p0_in(plain_port_pins_i),
    .p2_in(shared_port_i),
    .p4_in(key_port_i),
    .events(events)
  );

  // --------------------------------------------------------------------------
  // Interrupt edge detectors on the two upper key pins
  // --------------------------------------------------------------------------
  ppfm_edge_det u_edge_a (
    .pclk(pclk),
    .presetn(presetn),
    .level_in(key_port_i[6]),
    .edge_sel(edge_reg[1:0]),
    .hit(hit_a)
  );

  ppfm_edge_det u_edge_b (
    .pclk(pclk),
    .presetn(presetn),
    .level_in(key_port_i[7]),
    .edge_sel(edge_reg[3:2]),
    .hit(hit_b)
  );

  // Key return event: any falling edge among key pins in input mode
  assign key_hit = |(key_prev_reg & ~key_port_i & p4_dir_reg);
  assign events = {key_hit, hit_b, hit_a};

  // --------------------------------------------------------------------------
  // Pin drivers, all registered
  // --------------------------------------------------------------------------
  logic [7:0] p0_o_next;
  logic [7:0] p0_oe_next;
  logic [7:0] p0_pu_next;
  logic [7:0] p2_o_next;
  logic [7:0] p2_oe_next;
  logic [7:0] p4_o_next;
  logic [7:0] p4_oe_next;
  logic [7:0] p4_pu_next;
  logic ser_async;
  logic ser_clk_drive;

  assign ser_async = ser_reg[`PPFM_SER_ASYNC];
  assign ser_clk_drive = ser_reg[`PPFM_SER_CLK_OUT];

  // Direction bit 1 means input, so reset leaves every driver off
  always_comb begin
    p0_o_next = p0_out_reg;
    p0_oe_next = ~p0_dir_reg;
    p0_pu_next = p0_pu_reg & p0_dir_reg;
    p4_o_next = p4_out_reg;
    p4_oe_next = ~p4_dir_reg;
    p4_pu_next = p4_pu_reg & p4_dir_reg;
    p2_o_next = p2_out_reg;
    p2_oe_next = ~p2_dir_reg;
    // Control bits 0, 1 and 3 substitute peripheral data, direction still gates; bits 2 and 4 force input
    if (p2_ctl_reg[`PPFM_P2_BIT_CLK]) begin
      p2_o_next[`PPFM_P2_BIT_CLK] = sync_serial_clock_out;
      p2_oe_next[`PPFM_P2_BIT_CLK] = ~p2_dir_reg[`PPFM_P2_BIT_CLK] &
        ~ser_async & ser_clk_drive;
    end
    if (p2_ctl_reg[`PPFM_P2_BIT_SO]) begin
      p2_o_next[`PPFM_P2_BIT_SO] = ser_async ? async_transmit_data :
        sync_serial_data_out;
    end
    if (p2_ctl_reg[`PPFM_P2_BIT_SI]) begin
      p2_oe_next[`PPFM_P2_BIT_SI] = 1'b0;
    end
    if (p2_ctl_reg[`PPFM_P2_BIT_TMR]) begin
      p2_o_next[`PPFM_P2_BIT_TMR] = timer_b_output;
    end
    if (p2_ctl_reg[`PPFM_P2_BIT_CPT]) begin
      p2_oe_next[`PPFM_P2_BIT_CPT] = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      plain_port_pins_o <= 8'h00;
      plain_port_pins_oe <= 8'h00;
      plain_port_pullup <= 8'h00;
      shared_port_o <= 8'h00;
      shared_port_oe <= 8'h00;
      key_port_o <= 8'h00;
      key_port_oe <= 8'h00;
      key_port_pullup <= 8'h00;
      sync_serial_clock_in <= 1'b0;
      async_serial_clock_in <= 1'b0;
      sync_serial_data_in <= 1'b0;
      async_receive_data <= 1'b0;
      capture_edge_in <= 1'b0;
      key_return_inputs <= 8'h00;
      ext_irq_a <= 1'b0;
      ext_irq_b <= 1'b0;
      irq <= 1'b0;
      key_prev_reg <= 8'h00;
    end else begin
      plain_port_pins_o <= p0_o_next;
      plain_port_pins_oe <= p0_oe_next;
      plain_port_pullup <= p0_pu_next;
      shared_port_o <= p2_o_next;
      shared_port_oe <= p2_oe_next;
      key_port_o <= p4_o_next;
      key_port_oe <= p4_oe_next;
      key_port_pullup <= p4_pu_next;
      // Inputs seen only while the bit is in control operation
      sync_serial_clock_in <= p2_ctl_reg[0] & ~ser_async &
        shared_port_i[0];
      async_serial_clock_in <= p2_ctl_reg[0] & ser_async &
        shared_port_i[0];
      sync_serial_data_in <= p2_ctl_reg[2] & ~ser_async &
        shared_port_i[2];
      async_receive_data <= p2_ctl_reg[2] & ser_async &
        shared_port_i[2];
      capture_edge_in <= p2_ctl_reg[4] & shared_port_i[4];
      key_return_inputs <= key_port_i;
      ext_irq_a <= hit_a;
      ext_irq_b <= hit_b;
      irq <= |(stat_reg & mask_reg);
      key_prev_reg <= key_port_i;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  AST_P0_PULLUP_INPUT_ONLY: assert property (@(posedge pclk)
    disable iff (!presetn)
    ##1 (plain_port_pullup & plain_port_pins_oe) == 8'h00)
    else $error("pull-up on plain output pin");
  AST_P4_PULLUP: assert property (@(posedge pclk) disable iff (!presetn)
    (key_port_pullup & key_port_oe) == 8'h00)
    else $error("pull-up on key output pin");
  AST_P0_DIR: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> plain_port_pins_oe == ~$past(p0_dir_reg))
    else $error("plain port direction wrong");
  AST_RESET_INPUT: assert property (@(posedge pclk)
    $rose(presetn) |-> (shared_port_oe == 8'h00 && key_port_oe == 8'h00))
    else $error("pin driven after reset");
  AST_P2_DIR: assert property (@(posedge pclk) disable iff (!presetn)
    (p2_ctl_reg == 8'h00) |=> shared_port_oe == ~$past(p2_dir_reg))
    else $error("shared port direction wrong");
  AST_TMR_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    p2_ctl_reg[3] |=> shared_port_o[3] == $past(timer_b_output))
    else $error("timer output not routed");
  AST_TXD: assert property (@(posedge pclk) disable iff (!presetn)
    (p2_ctl_reg[1] && ser_async) |=>
      shared_port_o[1] == $past(async_transmit_data))
    else $error("transmit data not routed");
  AST_PLAIN_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    !p2_ctl_reg[3] |=> shared_port_o[3] == $past(p2_out_reg[3]))
    else $error("plain mode data wrong");
  AST_IRQ_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    |(stat_reg & mask_reg) |=> irq)
    else $error("interrupt not raised");
endmodule : ppfm_port_top

// ---- ppfm_board_model.sv ----
// Board-side model of one eight-pin port: drivers, pull-ups, float
`timescale 1ns/100ps
module ppfm_board_model #(
  parameter int WIDTH = 8
) (
  // Clock
  input wire logic pclk,
  // Device side of the pins
  input wire logic [WIDTH-1:0] drv_o,
  input wire logic [WIDTH-1:0] drv_oe,
  input wire logic [WIDTH-1:0] pull_en,
  // Board drivers
  input wire logic [WIDTH-1:0] ext_en,
  input wire logic [WIDTH-1:0] ext_val,
  // Resolved pin level
  output logic [WIDTH-1:0] pin
);
  // ---------------------------------------------------------------------
  // Pin resolution
  // ---------------------------------------------------------------------
  logic float_q = 1'b0;

  // Undriven wire wanders so a missing drive never reads as a lucky 0
  always @(posedge pclk) begin
    float_q <= ~float_q;
  end

  // Device drive first, then board drive, then pull-up
  always_comb begin
    for (int b = 0; b < WIDTH; b++) begin
      if (drv_oe[b]) pin[b] = drv_o[b];
      else if (ext_en[b]) pin[b] = ext_val[b];
      else if (pull_en[b]) pin[b] = 1'b1;
      else pin[b] = float_q;
    end
  end
endmodule : ppfm_board_model

// ---- tb_top.sv ----
// Self-checking testbench of the three-port pin block
`timescale 1ns/100ps
`include "ppfm_regs.svh"
module tb_top;
  // ---------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  logic [7:0] p0_i, p0_o, p0_oe, p0_pu, p2_i, p2_o, p2_oe;
  logic [7:0] p4_i, p4_o, p4_oe, p4_pu, kr;
  logic [7:0] e0_en = 8'h00, e0_v = 8'h00, e2_en = 8'h00, e2_v = 8'h00;
  logic [7:0] e4_en = 8'hC0, e4_v = 8'h00;
  logic clk_o = 1'b0, do_o = 1'b0, tx_o = 1'b0, tmr = 1'b0;
  logic clk_in, aclk_in, di_in, rx_in, cpt, irq_a, irq_b, irq;
  int errors = 0, check_count = 0, cycles = 0, cnt_a = 0, cnt_b = 0;

  // 10 MHz clock
  initial begin
    forever #50 pclk = ~pclk;
  end

  ppfm_port_top #(.WIDTH(8)) ppfm_port_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .plain_port_pins_i(p0_i), .plain_port_pins_o(p0_o),
    .plain_port_pins_oe(p0_oe), .plain_port_pullup(p0_pu),
    .shared_port_i(p2_i), .shared_port_o(p2_o), .shared_port_oe(p2_oe),
    .key_port_i(p4_i), .key_port_o(p4_o), .key_port_oe(p4_oe),
    .key_port_pullup(p4_pu), .sync_serial_clock_out(clk_o),
    .sync_serial_data_out(do_o), .async_transmit_data(tx_o),
    .sync_serial_clock_in(clk_in), .async_serial_clock_in(aclk_in),
    .sync_serial_data_in(di_in), .async_receive_data(rx_in),
    .timer_b_output(tmr), .capture_edge_in(cpt),
    .key_return_inputs(kr), .ext_irq_a(irq_a), .ext_irq_b(irq_b),
    .irq(irq));
  ppfm_board_model board_p0_i (.pclk(pclk), .drv_o(p0_o), .drv_oe(p0_oe),
    .pull_en(p0_pu), .ext_en(e0_en), .ext_val(e0_v), .pin(p0_i));
  ppfm_board_model board_p2_i (.pclk(pclk), .drv_o(p2_o), .drv_oe(p2_oe),
    .pull_en(8'h00), .ext_en(e2_en), .ext_val(e2_v), .pin(p2_i));
  ppfm_board_model board_p4_i (.pclk(pclk), .drv_o(p4_o), .drv_oe(p4_oe),
    .pull_en(p4_pu), .ext_en(e4_en), .ext_val(e4_v), .pin(p4_i));

  // Pulse counters and hang guard
  always @(posedge pclk) begin
    cycles++;
    if (irq_a === 1'b1) cnt_a++;
    if (irq_b === 1'b1) cnt_b++;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic end_sim();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One APB transfer; waits for pready, takes data at that edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    check(rd, exp);
  endtask : rchk

  // Config reaches pins one cycle after the write; margin for input sync
  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask : settle

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset();
    check({p0_oe, p2_oe, p4_oe}, 32'h0);
    check({p0_pu, p4_pu}, 32'h0);
    rchk(`PPFM_OFS_P0_DIR, 32'h000000FF);
    rchk(`PPFM_OFS_P2_DIR, 32'h000000FF);
    rchk(`PPFM_OFS_P4_DIR, 32'h000000FF);
  endtask : t_reset

  task automatic t_plain();
    e0_en <= 8'h03;
    e0_v <= 8'h01;
    wr(`PPFM_OFS_P0_OUT, 32'hA5);
    wr(`PPFM_OFS_P0_DIR, 32'h0F);
    wr(`PPFM_OFS_P0_PU, 32'hFF);
    settle();
    check(p0_oe, 32'hF0);
    check(p0_o & 8'hF0, 32'hA0);
    check(p0_pu, 32'h0F);
    rchk(`PPFM_OFS_P0_IN, 32'hAD);
    wr(`PPFM_OFS_P0_DIR, 32'hFF);
    settle();
    check({p0_oe, p0_pu}, 32'h00FF);
  endtask : t_plain

  task automatic t_shared();
    e2_en <= 8'h15;
    e2_v <= 8'h14;
    clk_o <= 1'b1;
    do_o <= 1'b1;
    tmr <= 1'b1;
    wr(`PPFM_OFS_P2_DIR, 32'h00);
    wr(`PPFM_OFS_SER_CFG, 32'h02);
    wr(`PPFM_OFS_P2_CTL, 32'h1F);
    settle();
    check(p2_oe, 32'hEB);
    check(p2_o & 8'h0B, 32'h0B);
    check({cpt, di_in, clk_in, aclk_in, rx_in}, 32'h1C);
    // Async mode: bit 0 turns input, bit 1 carries transmit data
    e2_v <= 8'h15;
    tx_o <= 1'b1;
    do_o <= 1'b0;
    wr(`PPFM_OFS_SER_CFG, 32'h01);
    settle();
    check(p2_oe, 32'hEA);
    check(p2_o & 8'h02, 32'h02);
    check({cpt, di_in, clk_in, aclk_in, rx_in}, 32'h13);
    wr(`PPFM_OFS_P2_CTL, 32'h00);
    wr(`PPFM_OFS_P2_OUT, 32'h5A);
    settle();
    check({p2_oe, p2_o}, 32'hFF5A);
    rchk(`PPFM_OFS_P2_IN, 32'h5A);
    check({cpt, rx_in}, 32'h0);
  endtask : t_shared

  task automatic t_key();
    ppfm_pkg::ppfm_edge_e md[4];
    int ex[4];
    int ba, bb;
    md = '{ppfm_pkg::PPFM_EDGE_RISE, ppfm_pkg::PPFM_EDGE_FALL,
           ppfm_pkg::PPFM_EDGE_BOTH, ppfm_pkg::PPFM_EDGE_OFF};
    ex = '{1, 1, 2, 0};
    wr(`PPFM_OFS_P4_PU, 32'h3F);
    settle();
    check({p4_pu, kr}, 32'h3F3F);
    wr(`PPFM_OFS_P4_OUT, 32'h01);
    wr(`PPFM_OFS_P4_DIR, 32'hFE);
    settle();
    check({p4_oe, p4_pu}, 32'h013E);
    check(p4_o, 32'h01);
    rchk(`PPFM_OFS_P4_IN, 32'h3F);
    wr(`PPFM_OFS_P4_DIR, 32'hFF);
    wr(`PPFM_OFS_IRQ_STAT, 32'h7);
    for (int m = 0; m < 4; m++) begin
      wr(`PPFM_OFS_EDGE, {28'h0, md[m], md[m]});
      settle();
      ba = cnt_a;
      bb = cnt_b;
      e4_v <= 8'hC0;
      settle();
      e4_v <= 8'h00;
      settle();
      check(cnt_a - ba, ex[m]);
      check(cnt_b - bb, ex[m]);
    end
    rchk(`PPFM_OFS_EDGE, 32'hF);
    // Status is sticky, masked, and cleared by writing one
    wr(`PPFM_OFS_IRQ_MASK, 32'h0);
    settle();
    check(irq, 32'h0);
    rchk(`PPFM_OFS_IRQ_STAT, 32'h7);
    wr(`PPFM_OFS_IRQ_MASK, 32'h1);
    settle();
    check(irq, 32'h1);
    wr(`PPFM_OFS_IRQ_STAT, 32'h1);
    settle();
    check(irq, 32'h0);
    rchk(`PPFM_OFS_IRQ_STAT, 32'h6);
  endtask : t_key

  task automatic t_unmapped();
    logic [31:0] rd;
    logic err;
    apb(1'b0, 12'h040, 32'h0, rd, err);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
  endtask : t_unmapped

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_plain();
    t_shared();
    t_key();
    t_unmapped();
    end_sim();
  end
endmodule : tb_top
